// ---- rtl/ddrci_pkg.sv ----
package ddrci_pkg;

    // Register byte addresses
    localparam logic [4:0] ADDR_STATUS = 5'h00;
    localparam logic [4:0] ADDR_ERROR = 5'h04;
    localparam logic [4:0] ADDR_CTRL = 5'h08;
    localparam logic [4:0] ADDR_MR0 = 5'h0C;
    localparam logic [4:0] ADDR_MR1 = 5'h10;
    localparam logic [4:0] ADDR_MR2 = 5'h14;
    localparam logic [4:0] ADDR_MR3 = 5'h18;

    // Address pin fields and last burst beat indexes
    localparam int AP_BIT = 10;
    localparam int DLL_RST_BIT = 8;
    localparam int BT_BIT = 3;
    localparam logic [2:0] BL8_CODE = 3'h3;
    localparam logic [2:0] IDX_LAST4 = 3'h3;
    localparam logic [2:0] IDX_LAST8 = 3'h7;

    // Error bits
    localparam int ERR_ACT = 0;
    localparam int ERR_RW = 1;
    localparam int ERR_MRS = 2;
    localparam int ERR_REF = 3;

    // Status bits
    localparam int ST_RUN = 8;
    localparam int ST_PDN = 9;
    localparam int ST_SREF = 10;
    localparam int ST_DLL = 11;
    localparam int ST_SEEN = 12;

    localparam logic CTRL_STRICT_RST = 1'b1;

    typedef enum logic [3:0] {OP_DESEL, OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_MRS, OP_REF, OP_RSVD} ddrci_op_type;
    typedef enum logic [1:0] {PWR_OFF, PWR_RUN, PWR_PDN, PWR_SREF} ddrci_pwr_type;

    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [13:0] addr;
        logic dm;
        logic [7:0] dq;
    } ddrci_pins_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic last;
        logic ap;
        logic [2:0] bank;
        logic [13:0] row;
        logic [9:0] col;
    } ddrci_beat_type;

    typedef struct packed {
        logic valid;
        logic we;
        logic [2:0] bank;
        logic [13:0] row;
        logic [9:0] col;
        logic [7:0] data;
    } ddrci_mem_type;

    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
    } ddrci_avreq_type;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } ddrci_avrsp_type;

    function automatic ddrci_op_type ddrci_decode(input ddrci_pins_type p);
        ddrci_op_type op;
        op = OP_RSVD;
        if (p.cs_n)
            op = OP_DESEL;
        else
        begin
            case ({p.ras_n, p.cas_n, p.we_n})
                3'h7: op = OP_NOP;
                3'h3: op = OP_ACT;
                3'h2: op = OP_PRE;
                3'h5: op = OP_RD;
                3'h4: op = OP_WR;
                3'h0: op = OP_MRS;
                3'h1: op = OP_REF;
                default: op = OP_RSVD;
            endcase
        end
        return op;
    endfunction

endpackage

// ---- rtl/ddrci_burst.sv ----
`timescale 1ns/10ps
module ddrci_burst (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_start,
    input wire logic i_write,
    input wire logic i_ap,
    input wire logic i_bl8,
    input wire logic i_intl,
    input wire logic [2:0] i_bank,
    input wire logic [13:0] i_row,
    input wire logic [9:0] i_col,
    output ddrci_pkg::ddrci_beat_type o_beat
);

    typedef struct packed {
        ddrci_pkg::ddrci_beat_type beat;
        logic [9:0] start;
        logic [2:0] idx;
        logic bl8;
        logic intl;
    } ddrci_bst_type;

    ddrci_bst_type st_q;
    ddrci_bst_type st_d;

    // Wraps inside the 4- or 8-column block of the start column
    function automatic logic [9:0] burst_col(input logic [9:0] s, input logic [2:0] i,
                                             input logic bl8, input logic intl);
        logic [2:0] sum;
        logic [9:0] c;
        sum = s[2:0] + i;
        c = s;
        if (bl8)
            c[2:0] = intl ? (s[2:0] ^ i) : sum;
        else
            c[1:0] = intl ? (s[1:0] ^ i[1:0]) : sum[1:0];
        return c;
    endfunction

    always_comb
    begin
        st_d = st_q;
        if (i_start)
        begin
            // A new command cuts a running burst short
            st_d.start = i_col;
            st_d.idx = 3'h0;
            st_d.bl8 = i_bl8;
            st_d.intl = i_intl;
            st_d.beat.valid = 1'b1;
            st_d.beat.write = i_write;
            st_d.beat.last = 1'b0;
            st_d.beat.ap = i_ap;
            st_d.beat.bank = i_bank;
            st_d.beat.row = i_row;
            st_d.beat.col = burst_col(i_col, 3'h0, i_bl8, i_intl);
        end
        else if (st_q.beat.valid && !st_q.beat.last)
        begin
            st_d.idx = st_q.idx + 3'h1;
            st_d.beat.col = burst_col(st_q.start, st_d.idx, st_q.bl8, st_q.intl);
            st_d.beat.last = (st_d.idx == (st_q.bl8 ? ddrci_pkg::IDX_LAST8 : ddrci_pkg::IDX_LAST4));
        end
        else
        begin
            st_d.beat.valid = 1'b0;
            st_d.beat.last = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign o_beat = st_q.beat;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    sequence s_quiet4;
        (!i_start) [*4];
    endsequence

    sequence s_quiet8;
        (!i_start) [*8];
    endsequence

    property p_bl4;
        (i_start && !i_bl8) ##1 s_quiet4 |-> (o_beat.valid && o_beat.last) ##1 !o_beat.valid;
    endproperty
    a_bl4: assert property (p_bl4) else $error("burst of four has wrong length");

    property p_bl8;
        (i_start && i_bl8) ##1 s_quiet8 |-> (o_beat.valid && o_beat.last) ##1 !o_beat.valid;
    endproperty
    a_bl8: assert property (p_bl8) else $error("burst of eight has wrong length");

    property p_seq4;
        (o_beat.valid && !o_beat.last && !st_q.bl8 && !st_q.intl && !i_start)
            |=> o_beat.col[1:0] == 2'($past(o_beat.col[1:0]) + 2'h1) && o_beat.col[9:2] == $past(o_beat.col[9:2]);
    endproperty
    a_seq4: assert property (p_seq4) else $error("sequential burst order broken");

endmodule // ddrci_burst

// ---- rtl/ddrci_top.sv ----
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
// How it works
// - Activate opens addressed row in idle bank
// - Read/write start column; A10 requests auto-precharge
// - Bank state checks; precharge one or all
// - Mode register write selected by bank bits
// - Refresh needs CKE high; CKE drop: self-refresh
// - CKE drop with NOP enters power-down
// - Write beats with DM high are discarded
// - Bursts of four or eight, programmed order
module ddrci_top (
    input wire logic i_clk,
    input wire logic i_rstn,
    input ddrci_pkg::ddrci_pins_type i_pins,
    input ddrci_pkg::ddrci_avreq_type i_av,
    output ddrci_pkg::ddrci_avrsp_type o_av,
    output ddrci_pkg::ddrci_mem_type o_mem
);

    typedef struct packed {
        logic cke_prev;
        ddrci_pkg::ddrci_pwr_type pwr;
        logic [7:0] open;
        logic [7:0][13:0] row;
        logic [3:0][13:0] mr;
        logic [3:0] seen;
        logic dll_rst;
        logic [3:0] err;
        logic strict;
        logic av_wait;
        logic [31:0] rdata;
        ddrci_pkg::ddrci_mem_type mem;
    } ddrci_state_type;

    ddrci_state_type st_q;
    ddrci_state_type st_d;
    ddrci_pkg::ddrci_op_type op;
    ddrci_pkg::ddrci_beat_type bst;
    logic cmd_on;
    logic all_idle;
    logic idle_nop;
    logic act_ok;
    logic rw_ok;
    logic mrs_ok;
    logic exit_ok;
    logic [3:0] err_set;
    logic [2:0] pin_ba;
    logic [1:0] pin_sel;
    logic [9:0] pin_col;

    function automatic logic [31:0] reg_read(input ddrci_state_type s, input logic [4:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            ddrci_pkg::ADDR_STATUS:
            begin
                w[7:0] = s.open;
                w[ddrci_pkg::ST_RUN] = (s.pwr == ddrci_pkg::PWR_RUN);
                w[ddrci_pkg::ST_PDN] = (s.pwr == ddrci_pkg::PWR_PDN);
                w[ddrci_pkg::ST_SREF] = (s.pwr == ddrci_pkg::PWR_SREF);
                w[ddrci_pkg::ST_DLL] = s.dll_rst;
                w[ddrci_pkg::ST_SEEN +: 4] = s.seen;
            end
            ddrci_pkg::ADDR_ERROR: w[3:0] = s.err;
            ddrci_pkg::ADDR_CTRL: w[0] = s.strict;
            ddrci_pkg::ADDR_MR0: w[13:0] = s.mr[0];
            ddrci_pkg::ADDR_MR1: w[13:0] = s.mr[1];
            ddrci_pkg::ADDR_MR2: w[13:0] = s.mr[2];
            ddrci_pkg::ADDR_MR3: w[13:0] = s.mr[3];
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    assign op = ddrci_pkg::ddrci_decode(i_pins);
    assign pin_ba = i_pins.ba;
    assign pin_sel = i_pins.ba[1:0];
    assign pin_col = i_pins.addr[9:0];
    // Commands count only with CKE high in this and the previous cycle
    assign cmd_on = (st_q.pwr == ddrci_pkg::PWR_RUN) && st_q.cke_prev && i_pins.cke;
    assign all_idle = (st_q.open == 8'h00);
    assign idle_nop = (op == ddrci_pkg::OP_NOP) || (op == ddrci_pkg::OP_DESEL);
    assign exit_ok = !st_q.cke_prev && i_pins.cke && idle_nop;
    assign act_ok = cmd_on && (op == ddrci_pkg::OP_ACT) && (!st_q.open[pin_ba] || !st_q.strict);
    assign rw_ok = cmd_on && (op == ddrci_pkg::OP_RD || op == ddrci_pkg::OP_WR)
                   && (st_q.open[pin_ba] || !st_q.strict);
    assign mrs_ok = cmd_on && (op == ddrci_pkg::OP_MRS) && (all_idle || !st_q.strict);

    // Misuse by the controller is logged even when strict mode is off
    always_comb
    begin
        err_set = 4'h0;
        err_set[ddrci_pkg::ERR_ACT] = cmd_on && (op == ddrci_pkg::OP_ACT) && st_q.open[pin_ba];
        err_set[ddrci_pkg::ERR_RW] = cmd_on && (op == ddrci_pkg::OP_RD || op == ddrci_pkg::OP_WR)
                                     && !st_q.open[pin_ba];
        err_set[ddrci_pkg::ERR_MRS] = cmd_on && (op == ddrci_pkg::OP_MRS) && !all_idle;
        err_set[ddrci_pkg::ERR_REF] = st_q.pwr == ddrci_pkg::PWR_RUN && st_q.cke_prev
                                      && op == ddrci_pkg::OP_REF && !all_idle;
    end

    ddrci_burst u_burst (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_start(rw_ok),
        .i_write(op == ddrci_pkg::OP_WR),
        .i_ap(i_pins.addr[ddrci_pkg::AP_BIT]),
        .i_bl8(st_q.mr[0][2:0] == ddrci_pkg::BL8_CODE),
        .i_intl(st_q.mr[0][ddrci_pkg::BT_BIT]),
        .i_bank(pin_ba),
        .i_row(st_q.row[pin_ba]),
        .i_col(pin_col),
        .o_beat(bst)
    );

    always_comb
    begin
        st_d = st_q;
        st_d.cke_prev = i_pins.cke;
        case (st_q.pwr)
            ddrci_pkg::PWR_OFF:
            begin
                if (exit_ok)
                    st_d.pwr = ddrci_pkg::PWR_RUN;
            end
            ddrci_pkg::PWR_RUN:
            begin
                if (st_q.cke_prev && !i_pins.cke)
                begin
                    if (op == ddrci_pkg::OP_REF && (all_idle || !st_q.strict))
                        st_d.pwr = ddrci_pkg::PWR_SREF;
                    else if (idle_nop)
                        st_d.pwr = ddrci_pkg::PWR_PDN;
                end
            end
            ddrci_pkg::PWR_PDN, ddrci_pkg::PWR_SREF:
            begin
                if (exit_ok)
                    st_d.pwr = ddrci_pkg::PWR_RUN;
            end
            default: st_d.pwr = ddrci_pkg::PWR_OFF;
        endcase

        // Self-timed close at burst end, before this cycle's command
        if (bst.valid && bst.last && bst.ap)
            st_d.open[bst.bank] = 1'b0;
        if (act_ok)
        begin
            st_d.open[pin_ba] = 1'b1;
            st_d.row[pin_ba] = i_pins.addr;
        end
        if (cmd_on && op == ddrci_pkg::OP_PRE)
        begin
            if (i_pins.addr[ddrci_pkg::AP_BIT])
                st_d.open = 8'h00;
            else
                st_d.open[pin_ba] = 1'b0;
        end
        if (mrs_ok)
        begin
            st_d.mr[pin_sel] = i_pins.addr;
            st_d.seen[pin_sel] = 1'b1;
            if (pin_sel == 2'h0)
                st_d.dll_rst = i_pins.addr[ddrci_pkg::DLL_RST_BIT];
        end

        // Array port: one beat per clock, DM sampled with the beat
        st_d.mem.valid = bst.valid;
        st_d.mem.we = bst.valid && bst.write && !i_pins.dm;
        st_d.mem.bank = bst.bank;
        st_d.mem.row = bst.row;
        st_d.mem.col = bst.col;
        st_d.mem.data = i_pins.dq;

        // One wait state, read data stands with waitrequest low
        if ((i_av.read || i_av.write) && st_q.av_wait)
        begin
            st_d.av_wait = 1'b0;
            st_d.rdata = reg_read(st_q, i_av.address);
        end
        else
            st_d.av_wait = 1'b1;
        st_d.err = st_q.err | err_set;
        if (i_av.write && !st_q.av_wait)
        begin
            if (i_av.address == ddrci_pkg::ADDR_ERROR)
                st_d.err = (st_q.err & ~i_av.writedata[3:0]) | err_set;
            if (i_av.address == ddrci_pkg::ADDR_CTRL)
                st_d.strict = i_av.writedata[0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_q <= '0;
            st_q.strict <= ddrci_pkg::CTRL_STRICT_RST;
            st_q.av_wait <= 1'b1;
        end
        else
            st_q <= st_d;
    end

    assign o_av.readdata = st_q.rdata;
    assign o_av.waitrequest = st_q.av_wait;
    assign o_mem = st_q.mem;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    sequence s_sref_entry;
        st_q.pwr == ddrci_pkg::PWR_RUN && st_q.cke_prev && !i_pins.cke && op == ddrci_pkg::OP_REF && all_idle;
    endsequence

    sequence s_pdn_entry;
        st_q.pwr == ddrci_pkg::PWR_RUN && st_q.cke_prev && !i_pins.cke && idle_nop;
    endsequence

    sequence s_wake;
        (st_q.pwr == ddrci_pkg::PWR_PDN || st_q.pwr == ddrci_pkg::PWR_SREF) && exit_ok;
    endsequence

    property p_act_open;
        act_ok |=> st_q.open[$past(pin_ba)] && st_q.row[$past(pin_ba)] == $past(i_pins.addr);
    endproperty
    a_act_open: assert property (p_act_open) else $error("activate did not open row");

    property p_rw_col;
        rw_ok |-> ##2 (o_mem.valid && o_mem.col == $past(pin_col, 2));
    endproperty
    a_rw_col: assert property (p_rw_col) else $error("burst not at start column");

    property p_auto_pre;
        (bst.valid && bst.last && bst.ap && !act_ok) |=> !st_q.open[$past(bst.bank)];
    endproperty
    a_auto_pre: assert property (p_auto_pre) else $error("auto-precharge left bank open");

    property p_pre_all;
        (cmd_on && op == ddrci_pkg::OP_PRE && i_pins.addr[ddrci_pkg::AP_BIT]) |=> st_q.open == 8'h00;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

    property p_act_busy;
        (cmd_on && op == ddrci_pkg::OP_ACT && st_q.open[pin_ba]) |=> st_q.err[ddrci_pkg::ERR_ACT];
    endproperty
    a_act_busy: assert property (p_act_busy) else $error("activate to open bank not flagged");

    property p_mrs;
        mrs_ok |=> st_q.mr[$past(pin_sel)] == $past(i_pins.addr);
    endproperty
    a_mrs: assert property (p_mrs) else $error("mode register not written");

    property p_sref;
        s_sref_entry |=> st_q.pwr == ddrci_pkg::PWR_SREF;
    endproperty
    a_sref: assert property (p_sref) else $error("self refresh not entered");

    property p_pdn;
        s_pdn_entry |=> st_q.pwr == ddrci_pkg::PWR_PDN ##1 (st_q.pwr == ddrci_pkg::PWR_PDN || i_pins.cke);
    endproperty
    a_pdn: assert property (p_pdn) else $error("power-down not entered");

    property p_wake;
        s_wake |=> st_q.pwr == ddrci_pkg::PWR_RUN;
    endproperty
    a_wake: assert property (p_wake) else $error("low power exit failed");

    property p_dm_mask;
        (bst.valid && bst.write && i_pins.dm) |=> o_mem.valid && !o_mem.we;
    endproperty
    a_dm_mask: assert property (p_dm_mask) else $error("masked beat was stored");

    property p_dm_store;
        (bst.valid && bst.write && !i_pins.dm) |=> o_mem.we && o_mem.data == $past(i_pins.dq);
    endproperty
    a_dm_store: assert property (p_dm_store) else $error("unmasked beat not stored");

    property p_mrs_busy;
        (cmd_on && op == ddrci_pkg::OP_MRS && !all_idle && st_q.strict)
            |=> st_q.mr == $past(st_q.mr) && st_q.err[ddrci_pkg::ERR_MRS];
    endproperty
    a_mrs_busy: assert property (p_mrs_busy) else $error("mode write with open bank not refused");

    property p_rw_idle;
        (cmd_on && (op == ddrci_pkg::OP_RD || op == ddrci_pkg::OP_WR) && !st_q.open[pin_ba])
            |=> st_q.err[ddrci_pkg::ERR_RW];
    endproperty
    a_rw_idle: assert property (p_rw_idle) else $error("access to idle bank not flagged");

    // Low-power states must ignore row commands
    property p_asleep;
        (st_q.pwr != ddrci_pkg::PWR_RUN && op == ddrci_pkg::OP_ACT && !bst.valid) |=> st_q.open == $past(st_q.open);
    endproperty
    a_asleep: assert property (p_asleep) else $error("activate acted outside run state");

endmodule // ddrci_top

// ---- sim/ddrci_ctrl_model.sv ----
`timescale 1ns/10ps
module ddrci_ctrl_model (
    input wire logic i_clk,
    output ddrci_pkg::ddrci_pins_type o_pins
);
    int seed = 32'hF5064E80;

    initial o_pins = '0;

    // Fresh dq and dm every cycle, so masked and stored beats mix
    task automatic cyc(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a, input logic cke);
        logic [31:0] r;
        r = $random(seed);
        @(posedge i_clk);
        o_pins <= {cke, c, b, a, r[8], r[7:0]};
    endtask

    // Address bits change on idle cycles too; the device must ignore them
    task automatic nop();
        logic [31:0] r;
        r = $random(seed);
        cyc({r[0], 3'h7}, r[3:1], r[17:4], 1'b1);
    endtask

    task automatic cmd(input ddrci_pkg::ddrci_op_type op, input logic [2:0] b, input logic [13:0] a, input int gap);
        logic [3:0] c;
        case (op)
            ddrci_pkg::OP_ACT: c = 4'h3;
            ddrci_pkg::OP_PRE: c = 4'h2;
            ddrci_pkg::OP_RD: c = 4'h5;
            ddrci_pkg::OP_WR: c = 4'h4;
            ddrci_pkg::OP_MRS: c = 4'h0;
            ddrci_pkg::OP_REF: c = 4'h1;
            default: c = 4'h7;
        endcase
        cyc(c, b, a, 1'b1);
        repeat (gap) nop();
    endtask

    // No ODT pin on this block; only CKE low is modelled
    task automatic init();
        repeat (4000) cyc(4'hF, 3'h0, 14'h0000, 1'b0);
        cyc(4'h7, 3'h0, 14'h0000, 1'b1);
        repeat (8) nop();
        cmd(ddrci_pkg::OP_PRE, 3'h0, 14'h0400, 2);
        cmd(ddrci_pkg::OP_MRS, 3'h2, 14'h0080, 2);
        cmd(ddrci_pkg::OP_MRS, 3'h3, 14'h0000, 2);
        cmd(ddrci_pkg::OP_MRS, 3'h1, 14'h0004, 2);
        cmd(ddrci_pkg::OP_MRS, 3'h0, 14'h0103, 2);
        cmd(ddrci_pkg::OP_PRE, 3'h0, 14'h0400, 2);
        cmd(ddrci_pkg::OP_REF, 3'h0, 14'h0000, 4);
        cmd(ddrci_pkg::OP_REF, 3'h0, 14'h0000, 4);
        cmd(ddrci_pkg::OP_MRS, 3'h0, 14'h0003, 2);
        repeat (200) nop();
        cmd(ddrci_pkg::OP_MRS, 3'h1, 14'h0384, 2);
        cmd(ddrci_pkg::OP_MRS, 3'h1, 14'h0004, 2);
    endtask
endmodule // ddrci_ctrl_model

// ---- sim/ddrci_top_tb.sv ----
`timescale 1ns/10ps
module ddrci_top_tb;
    logic i_clk;
    logic i_rstn;
    ddrci_pkg::ddrci_pins_type pins;
    ddrci_pkg::ddrci_pins_type pins_q;
    ddrci_pkg::ddrci_avreq_type av_req;
    ddrci_pkg::ddrci_avrsp_type av_rsp;
    ddrci_pkg::ddrci_mem_type mem;
    ddrci_pkg::ddrci_mem_type mem_exp[$];
    logic [31:0] reg_exp[$];
    logic [13:0] rows [8];
    int mismatches;
    int n_compared;

    ddrci_ctrl_model u_ctrl (.i_clk(i_clk), .o_pins(pins));
    ddrci_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_pins(pins), .i_av(av_req), .o_av(av_rsp), .o_mem(mem));

    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    task automatic fail(input string msg);
        mismatches++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
            fail($sformatf("readdata %h, expected %h", got, exp));
    endtask

    // Mask and data are taken from the pins of the cycle before the beat
    task automatic cmp_mem(input ddrci_pkg::ddrci_mem_type got, input ddrci_pkg::ddrci_mem_type e,
                           input ddrci_pkg::ddrci_pins_type p);
        logic we;
        we = e.we & ~p.dm;
        n_compared++;
        if (got.we !== we || got.bank !== e.bank || got.row !== e.row || got.col !== e.col || (we && got.data !== p.dq))
            fail($sformatf("beat %h, expected col %h we %b", got, e.col, we));
    endtask

    always @(posedge i_clk)
    begin
        if (i_rstn === 1'b1 && mem.valid === 1'b1)
        begin
            if (mem_exp.size() == 0)
                fail("beat with none expected");
            else
                cmp_mem(mem, mem_exp.pop_front(), pins_q);
        end
        if (i_rstn === 1'b1 && av_rsp.waitrequest === 1'b0 && av_req.read === 1'b1)
        begin
            if (reg_exp.size() == 0)
                fail("read answer with none expected");
            else
                cmp_reg(av_rsp.readdata, reg_exp.pop_front());
        end
        pins_q <= pins;
    end

    // Waits as long as the slave stalls; only the watchdog ends a hang
    task automatic av(input logic rd, input logic [4:0] a, input logic [31:0] d);
        @(posedge i_clk);
        av_req <= '{read: rd, write: ~rd, address: a, writedata: d};
        do
            @(posedge i_clk);
        while (av_rsp.waitrequest !== 1'b0);
        av_req <= '0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        reg_exp.push_back(e);
        av(1'b1, a, 32'h00000000);
    endtask

    task automatic act(input logic [2:0] b, input logic [13:0] r);
        rows[b] = r;
        u_ctrl.cmd(ddrci_pkg::OP_ACT, b, r, 2);
    endtask

    // Notes the first keep beats, then issues the command
    task automatic burst(input logic w, input logic [2:0] b, input logic [9:0] c, input logic ap,
                         input int bl, input logic il, input int keep, input int gap);
        logic [9:0] m;
        m = 10'(bl - 1);
        for (int k = 0; k < keep; k++)
            mem_exp.push_back('{valid: 1'b1, we: w, bank: b, row: rows[b],
                col: (c & ~m) | ((il ? c ^ 10'(k) : c + 10'(k)) & m), data: 8'h00});
        u_ctrl.cmd(w ? ddrci_pkg::OP_WR : ddrci_pkg::OP_RD, b, {3'h0, ap, c}, gap);
    endtask

    task automatic end_test(input string s);
        if (mem_exp.size() != 0)
            fail("beats missing");
        $display("test %s finished", s);
    endtask

    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        #(50 * 10000);
        fail("watchdog expired");
        test_done();
    end

    initial
    begin
        av_req = '0;
        i_rstn = 1'b0;
        mismatches = 0;
        n_compared = 0;
        repeat (10) @(posedge i_clk);
        i_rstn <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd(5'(i * 4), (i == 2) ? 32'h00000001 : 32'h00000000);
        end_test("reset");
        u_ctrl.init();
        rd(ddrci_pkg::ADDR_STATUS, 32'h0000F100);
        rd(ddrci_pkg::ADDR_MR0, 32'h00000003);
        rd(ddrci_pkg::ADDR_MR1, 32'h00000004);
        rd(ddrci_pkg::ADDR_MR2, 32'h00000080);
        rd(ddrci_pkg::ADDR_MR3, 32'h00000000);
        av(1'b0, ddrci_pkg::ADDR_STATUS, 32'hFFFFFFFF);
        rd(ddrci_pkg::ADDR_STATUS, 32'h0000F100);
        end_test("init");
        act(3'h2, 14'h3A5C);
        rd(ddrci_pkg::ADDR_STATUS, 32'h0000F104);
        burst(1'b1, 3'h2, 10'h005, 1'b0, 8, 1'b0, 8, 10);
        burst(1'b0, 3'h2, 10'h3FB, 1'b1, 8, 1'b0, 8, 12);
        rd(ddrci_pkg::ADDR_STATUS, 32'h0000F100);
        act(3'h5, 14'h0001);
        act(3'h1, 14'h2FFF);
        rd(ddrci_pkg::ADDR_STATUS, 32'h0000F122);
        u_ctrl.cmd(ddrci_pkg::OP_PRE, 3'h5, 14'h3BFF, 2);
        rd(ddrci_pkg::ADDR_STATUS, 32'h0000F102);
        end_test("banks");
        // Illegal commands go out while bank 1 stays open
        u_ctrl.cmd(ddrci_pkg::OP_ACT, 3'h1, 14'h1234, 2);
        rd(ddrci_pkg::ADDR_ERROR, 32'h00000001);
        u_ctrl.cmd(ddrci_pkg::OP_RD, 3'h0, 14'h0000, 10);
        rd(ddrci_pkg::ADDR_ERROR, 32'h00000003);
        u_ctrl.cmd(ddrci_pkg::OP_MRS, 3'h0, 14'h0007, 2);
        rd(ddrci_pkg::ADDR_ERROR, 32'h00000007);
        rd(ddrci_pkg::ADDR_MR0, 32'h00000003);
        u_ctrl.cmd(ddrci_pkg::OP_REF, 3'h0, 14'h0000, 4);
        rd(ddrci_pkg::ADDR_ERROR, 32'h0000000F);
        av(1'b0, ddrci_pkg::ADDR_ERROR, 32'h0000000F);
        av(1'b0, ddrci_pkg::ADDR_CTRL, 32'h00000000);
        rd(ddrci_pkg::ADDR_CTRL, 32'h00000000);
        // Strict off: activate to the open bank executes and moves its row
        act(3'h1, 14'h1234);
        burst(1'b0, 3'h1, 10'h010, 1'b0, 8, 1'b0, 8, 10);
        rd(ddrci_pkg::ADDR_ERROR, 32'h00000001);
        av(1'b0, ddrci_pkg::ADDR_ERROR, 32'h00000001);
        av(1'b0, ddrci_pkg::ADDR_CTRL, 32'h00000001);
        u_ctrl.cmd(ddrci_pkg::OP_PRE, 3'h6, 14'h0400, 2);
        u_ctrl.cmd(ddrci_pkg::OP_REF, 3'h0, 14'h0000, 4);
        rd(ddrci_pkg::ADDR_ERROR, 32'h00000000);
        rd(ddrci_pkg::ADDR_STATUS, 32'h0000F100);
        end_test("refused");
        u_ctrl.cmd(ddrci_pkg::OP_MRS, 3'h0, 14'h010A, 2);
        rd(ddrci_pkg::ADDR_STATUS, 32'h0000F900);
        u_ctrl.cmd(ddrci_pkg::OP_MRS, 3'h0, 14'h000A, 2);
        rd(ddrci_pkg::ADDR_MR0, 32'h0000000A);
        act(3'h3, 14'h0C3A);
        burst(1'b0, 3'h3, 10'h008, 1'b0, 4, 1'b1, 2, 1);
        burst(1'b1, 3'h3, 10'h006, 1'b0, 4, 1'b1, 4, 8);
        u_ctrl.cmd(ddrci_pkg::OP_PRE, 3'h0, 14'h0400, 2);
        u_ctrl.cmd(ddrci_pkg::OP_MRS, 3'h0, 14'h0002, 2);
        act(3'h4, 14'h1111);
        burst(1'b1, 3'h4, 10'h00E, 1'b1, 4, 1'b0, 4, 8);
        rd(ddrci_pkg::ADDR_MR0, 32'h00000002);
        end_test("bl4");
        u_ctrl.cyc(4'h7, 3'h0, 14'h0000, 1'b0);
        rd(ddrci_pkg::ADDR_STATUS, 32'h0000F200);
        u_ctrl.cyc(4'h3, 3'h4, 14'h0001, 1'b0);
        u_ctrl.cyc(4'hF, 3'h0, 14'h0000, 1'b1);
        rd(ddrci_pkg::ADDR_STATUS, 32'h0000F100);
        u_ctrl.cyc(4'h1, 3'h0, 14'h0000, 1'b0);
        rd(ddrci_pkg::ADDR_STATUS, 32'h0000F400);
        u_ctrl.cyc(4'h7, 3'h0, 14'h0000, 1'b1);
        rd(ddrci_pkg::ADDR_STATUS, 32'h0000F100);
        end_test("power");
        repeat (5) @(posedge i_clk);
        test_done();
    end
endmodule // ddrci_top_tb
